// [core/cpu_regs_pkg.sv]
// constants, field layout and state type of the cpu register file
// How it works
// RULE_01 - thirteen architectural registers held in total
// RULE_02 - data, address, frame base form two banks
// RULE_03 - 16-bit data registers; first two byte-split
// RULE_04 - third/first and fourth/second pair to 32 bits
// RULE_05 - 16-bit address registers, paired into 32 bits
// RULE_06 - 16-bit frame base for frame-relative addressing
// RULE_07 - 20-bit vector table base register
// RULE_08 - 20-bit program counter, next instruction address
// RULE_09 - user and interrupt stack pointers 16 bits
// RULE_10 - stack select 0 interrupt, 1 user pointer
// RULE_11 - stack select cleared by interrupt acknowledge
// RULE_12 - 16-bit static base register
// RULE_13 - flag register is 11 bits wide
// RULE_14 - carry flag captures carry, borrow, shifted bit
// RULE_15 - zero flag set on zero result
// RULE_16 - sign flag set on negative result
// RULE_17 - overflow flag set on overflow
// RULE_18 - bank select flag picks bank 0 or 1
// RULE_19 - interrupt enable flag gates maskable interrupts
// RULE_20 - acknowledge clears interrupt enable flag
// RULE_21 - priority level field 3 bits, levels 0-7
// RULE_22 - accept only priority strictly above level
// RULE_23 - byte write keeps the other half
// RULE_24 - bank switch redirects accesses, preserves other bank
package cpu_regs_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int WORD_W = 16;
	localparam int ADDR20_W = 20;
	localparam int FLG_W = 11;
	localparam int IPL_W = 3;
	localparam int NUM_BANKS = 2;
	localparam int BANK_REGS = 7;
	localparam int RADDR_W = 5;
	localparam int BUS_W = 32;
	localparam int VEC_W = 6;

	// ****************************************
	// register index map
	// ****************************************
	localparam logic [4:0] REG_D0 = 5'h00;
	localparam logic [4:0] REG_D1 = 5'h01;
	localparam logic [4:0] REG_D2 = 5'h02;
	localparam logic [4:0] REG_D3 = 5'h03;
	localparam logic [4:0] REG_A0 = 5'h04;
	localparam logic [4:0] REG_A1 = 5'h05;
	localparam logic [4:0] REG_FB = 5'h06;
	localparam logic [4:0] REG_VECTOR_TABLE_BASE = 5'h07;
	localparam logic [4:0] REG_PC = 5'h08;
	localparam logic [4:0] REG_USP = 5'h09;
	localparam logic [4:0] REG_ISP = 5'h0A;
	localparam logic [4:0] REG_SB = 5'h0B;
	localparam logic [4:0] REG_FLG = 5'h0C;
	localparam logic [4:0] REG_D0L = 5'h0D;
	localparam logic [4:0] REG_D0H = 5'h0E;
	localparam logic [4:0] REG_D1L = 5'h0F;
	localparam logic [4:0] REG_D1H = 5'h10;
	localparam logic [4:0] REG_DPAIRL = 5'h11;
	localparam logic [4:0] REG_DPAIRH = 5'h12;
	localparam logic [4:0] REG_APAIR = 5'h13;
	localparam logic [4:0] REG_SPACT = 5'h14;

	// ****************************************
	// flag bit positions
	// ****************************************
	localparam int FLG_C = 0;
	localparam int FLG_D = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_S = 3;
	localparam int FLG_B = 4;
	localparam int FLG_O = 5;
	localparam int FLG_I = 6;
	localparam int FLG_U = 7;
	localparam int FLG_IPL_LO = 8;
	localparam int FLG_IPL_HI = 10;

	// software interrupt vectors up to this one switch stacks
	localparam logic [5:0] SWINT_U_LAST = 6'h1F;

	// ****************************************
	// state of the register file
	// ****************************************
	typedef struct packed {
		logic [NUM_BANKS-1:0][BANK_REGS-1:0][WORD_W-1:0] bank; // RULE_02
		logic [ADDR20_W-1:0] vector_table_base;
		logic [ADDR20_W-1:0] pc;
		logic [WORD_W-1:0] user_stack_pointer;
		logic [WORD_W-1:0] interrupt_stack_pointer;
		logic [WORD_W-1:0] sb;
		logic [FLG_W-1:0] processor_flags;
		logic [BUS_W-1:0] rdata;
	} regs_state_t;

	localparam regs_state_t STATE_RESET = '0;

endpackage

// [core/cpu_register_file_flags.sv]
// architectural register set and flag register of the cpu core
`timescale 1ns/1ps
module cpu_register_file_flags import cpu_regs_pkg::*; (
	input wire logic clk_sys, // core clock
	input wire logic reset, // sync reset, active high
	input wire logic [RADDR_W-1:0] regAddr, // register index
	input wire logic [BUS_W-1:0] wrData, // write data
	input wire logic wrStb, // write strobe
	input wire logic rdStb, // read strobe
	output logic [BUS_W-1:0] rdData, // read data, cycle after strobe
	input wire logic pcLoad, // load program counter
	input wire logic [ADDR20_W-1:0] pcLoadVal, // jump target
	input wire logic pcInc, // advance program counter
	input wire logic [2:0] pcIncAmt, // instruction length
	input wire logic spAdj, // adjust active stack pointer
	input wire logic [WORD_W-1:0] spDelta, // two's complement delta
	input wire logic aluFlagWe, // update arithmetic flags
	input wire logic aluByteOp, // result is 8 bits wide
	input wire logic [WORD_W-1:0] aluResult, // alu result
	input wire logic aluCarry, // carry, borrow or shifted bit
	input wire logic aluOverflow, // overflow
	input wire logic irqRequest, // maskable request pending
	input wire logic [IPL_W-1:0] irqPriority, // its priority
	output logic irqAccept, // request may be taken
	input wire logic hwIntAck, // hardware interrupt acknowledged
	input wire logic swIntExec, // software interrupt executed
	input wire logic [VEC_W-1:0] swIntVector, // its vector number
	output logic bankSel, // active bank
	output logic [WORD_W-1:0] addrZero, // active address reg zero
	output logic [WORD_W-1:0] addrOne, // active address reg one
	output logic [WORD_W-1:0] frameBase, // active frame base
	output logic [WORD_W-1:0] staticBase, // static base
	output logic [WORD_W-1:0] activeSp, // selected stack pointer
	output logic [ADDR20_W-1:0] programCounter, // next instruction
	output logic [ADDR20_W-1:0] vectorTableBase, // vector table
	output logic [FLG_W-1:0] processorFlags // flag register
);

	// ****************************************
	// state
	// ****************************************
	regs_state_t st_ff;
	regs_state_t nxt_st;
	logic bk;
	logic [IPL_W-1:0] processor_priority_level;

	assign bk = st_ff.processor_flags[FLG_B];
	assign processor_priority_level = st_ff.processor_flags[FLG_IPL_HI:FLG_IPL_LO];

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = '0;
		// register port writes go to the bank named by the flag
		if (wrStb) begin
			unique case (regAddr)
				REG_D0, REG_D1, REG_D2, REG_D3, REG_A0, REG_A1, REG_FB: begin
					nxt_st.bank[bk][regAddr[2:0]] = wrData[15:0]; // RULE_24
				end
				REG_VECTOR_TABLE_BASE: nxt_st.vector_table_base = wrData[19:0]; // RULE_07
				REG_PC: nxt_st.pc = wrData[19:0]; // RULE_08
				REG_USP: nxt_st.user_stack_pointer = wrData[15:0]; // RULE_09
				REG_ISP: nxt_st.interrupt_stack_pointer = wrData[15:0]; // RULE_09
				REG_SB: nxt_st.sb = wrData[15:0]; // RULE_12
				REG_FLG: nxt_st.processor_flags = wrData[10:0]; // RULE_13
				REG_D0L: nxt_st.bank[bk][0][7:0] = wrData[7:0]; // RULE_23
				REG_D0H: nxt_st.bank[bk][0][15:8] = wrData[7:0]; // RULE_23
				REG_D1L: nxt_st.bank[bk][1][7:0] = wrData[7:0]; // RULE_23
				REG_D1H: nxt_st.bank[bk][1][15:8] = wrData[7:0]; // RULE_03
				REG_DPAIRL: begin
					nxt_st.bank[bk][0] = wrData[15:0]; // RULE_04
					nxt_st.bank[bk][2] = wrData[31:16]; // RULE_04
				end
				REG_DPAIRH: begin
					nxt_st.bank[bk][1] = wrData[15:0]; // RULE_04
					nxt_st.bank[bk][3] = wrData[31:16]; // RULE_04
				end
				REG_APAIR: begin
					nxt_st.bank[bk][4] = wrData[15:0]; // RULE_05
					nxt_st.bank[bk][5] = wrData[31:16]; // RULE_05
				end
				REG_SPACT: begin
					if (st_ff.processor_flags[FLG_U]) begin
						nxt_st.user_stack_pointer = wrData[15:0]; // RULE_10
					end else begin
						nxt_st.interrupt_stack_pointer = wrData[15:0]; // RULE_10
					end
				end
				default: begin
				end
			endcase
		end
		// register port reads, answered one cycle later
		if (rdStb) begin
			unique case (regAddr)
				REG_D0, REG_D1, REG_D2, REG_D3, REG_A0, REG_A1, REG_FB: begin
					nxt_st.rdata = {16'h0000, st_ff.bank[bk][regAddr[2:0]]};
				end
				REG_VECTOR_TABLE_BASE: nxt_st.rdata = {12'h000, st_ff.vector_table_base};
				REG_PC: nxt_st.rdata = {12'h000, st_ff.pc}; // RULE_08
				REG_USP: nxt_st.rdata = {16'h0000, st_ff.user_stack_pointer};
				REG_ISP: nxt_st.rdata = {16'h0000, st_ff.interrupt_stack_pointer};
				REG_SB: nxt_st.rdata = {16'h0000, st_ff.sb};
				REG_FLG: nxt_st.rdata = {21'h000000, st_ff.processor_flags};
				REG_D0L: nxt_st.rdata = {24'h000000, st_ff.bank[bk][0][7:0]};
				REG_D0H: nxt_st.rdata = {24'h000000, st_ff.bank[bk][0][15:8]};
				REG_D1L: nxt_st.rdata = {24'h000000, st_ff.bank[bk][1][7:0]};
				REG_D1H: nxt_st.rdata = {24'h000000, st_ff.bank[bk][1][15:8]};
				REG_DPAIRL: nxt_st.rdata = {st_ff.bank[bk][2], st_ff.bank[bk][0]};
				REG_DPAIRH: nxt_st.rdata = {st_ff.bank[bk][3], st_ff.bank[bk][1]};
				REG_APAIR: nxt_st.rdata = {st_ff.bank[bk][5], st_ff.bank[bk][4]};
				REG_SPACT: nxt_st.rdata = {16'h0000, activeSp};
				default: nxt_st.rdata = '0;
			endcase
		end
		// sequencer updates override the port
		if (pcLoad) begin
			nxt_st.pc = pcLoadVal; // RULE_08
		end else if (pcInc) begin
			nxt_st.pc = st_ff.pc + {17'h00000, pcIncAmt}; // RULE_08
		end
		if (spAdj) begin
			if (st_ff.processor_flags[FLG_U]) begin
				nxt_st.user_stack_pointer = st_ff.user_stack_pointer + spDelta; // RULE_10
			end else begin
				nxt_st.interrupt_stack_pointer = st_ff.interrupt_stack_pointer + spDelta; // RULE_10
			end
		end
		// arithmetic flags from the alu result
		if (aluFlagWe) begin
			nxt_st.processor_flags[FLG_C] = aluCarry; // RULE_14
			nxt_st.processor_flags[FLG_O] = aluOverflow; // RULE_17
			if (aluByteOp) begin
				nxt_st.processor_flags[FLG_Z] = (aluResult[7:0] == 8'h00); // RULE_15
				nxt_st.processor_flags[FLG_S] = aluResult[7]; // RULE_16
			end else begin
				nxt_st.processor_flags[FLG_Z] = (aluResult == 16'h0000); // RULE_15
				nxt_st.processor_flags[FLG_S] = aluResult[15]; // RULE_16
			end
		end
		// acknowledge clears enable and stack select, software vectors up to 0x1F stack select only, last
		if (hwIntAck) begin
			nxt_st.processor_flags[FLG_I] = 1'b0; // RULE_20
			nxt_st.processor_flags[FLG_U] = 1'b0; // RULE_11
		end
		if (swIntExec && swIntVector <= SWINT_U_LAST) begin
			nxt_st.processor_flags[FLG_U] = 1'b0; // RULE_11
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_ff <= STATE_RESET; // RULE_01
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// strictly higher priority than the level, and enabled
	// enable flag masks every maskable request
	assign irqAccept = irqRequest && st_ff.processor_flags[FLG_I] // RULE_19
		&& irqPriority > processor_priority_level; // RULE_22
	assign activeSp = st_ff.processor_flags[FLG_U] ? st_ff.user_stack_pointer : st_ff.interrupt_stack_pointer; // RULE_10
	assign bankSel = bk; // RULE_18
	assign addrZero = st_ff.bank[bk][4]; // RULE_05
	assign addrOne = st_ff.bank[bk][5];
	assign frameBase = st_ff.bank[bk][6]; // RULE_06
	assign staticBase = st_ff.sb; // RULE_12
	assign programCounter = st_ff.pc;
	assign vectorTableBase = st_ff.vector_table_base;
	assign processorFlags = st_ff.processor_flags; // RULE_21
	assign rdData = st_ff.rdata;

	// ****************************************
	// checks
	// ****************************************
	a_ack_clears_ie: assert property ( // RULE_20
		@(posedge clk_sys) disable iff (reset)
		hwIntAck |=> !processorFlags[FLG_I])
	else $error("interrupt enable not cleared by acknowledge");

	a_stack_sel_clear: assert property ( // RULE_11
		@(posedge clk_sys) disable iff (reset)
		(hwIntAck || (swIntExec && swIntVector <= SWINT_U_LAST))
		|=> !processorFlags[FLG_U])
	else $error("stack select not cleared on interrupt entry");

	a_sp_select: assert property ( // RULE_10
		@(posedge clk_sys) disable iff (reset)
		spAdj && processorFlags[FLG_U]
		|=> st_ff.user_stack_pointer == $past(st_ff.user_stack_pointer) + $past(spDelta))
	else $error("user stack pointer not adjusted");

	a_isp_adjust: assert property ( // RULE_10
		@(posedge clk_sys) disable iff (reset)
		spAdj && !processorFlags[FLG_U]
		|=> st_ff.interrupt_stack_pointer == $past(st_ff.interrupt_stack_pointer) + $past(spDelta))
	else $error("interrupt stack pointer not adjusted");

	a_usp_write: assert property ( // RULE_09
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_USP && !spAdj
		|=> st_ff.user_stack_pointer == $past(wrData[15:0]))
	else $error("user stack pointer write lost");

	a_swi_high_keep: assert property ( // RULE_11
		@(posedge clk_sys) disable iff (reset)
		swIntExec && swIntVector > SWINT_U_LAST && !hwIntAck
		&& processorFlags[FLG_U] && !(wrStb && regAddr == REG_FLG)
		|=> processorFlags[FLG_U])
	else $error("stack select cleared by high vector");

	a_ipl_keep: assert property ( // RULE_21
		@(posedge clk_sys) disable iff (reset)
		hwIntAck && !(wrStb && regAddr == REG_FLG)
		|=> processorFlags[10:8] == $past(processorFlags[10:8]))
	else $error("priority level changed by acknowledge");

	a_irq_gate: assert property ( // RULE_19
		@(posedge clk_sys) disable iff (reset)
		!processorFlags[FLG_I] |-> !irqAccept)
	else $error("interrupt accepted while disabled");

	a_irq_priority: assert property ( // RULE_22
		@(posedge clk_sys) disable iff (reset)
		irqRequest && processorFlags[FLG_I]
		|-> irqAccept == (irqPriority > processorFlags[10:8]))
	else $error("interrupt priority compare wrong");

	a_byte_keep: assert property ( // RULE_23
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_D0L
		|=> st_ff.bank[bankSel][0] == {$past(st_ff.bank[bankSel][0][15:8]),
			$past(wrData[7:0])})
	else $error("byte write disturbed other half");

	a_bank_keep: assert property ( // RULE_24
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_D0 && !bankSel |=> $stable(st_ff.bank[1]))
	else $error("write leaked into inactive bank");

	a_pair_write: assert property ( // RULE_04
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_DPAIRL && !bankSel
		|=> st_ff.bank[0][2] == $past(wrData[31:16])
		&& st_ff.bank[0][0] == $past(wrData[15:0]))
	else $error("pair write missed a half");

	a_pair_high: assert property ( // RULE_04
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_DPAIRH
		|=> st_ff.bank[bankSel][3] == $past(wrData[31:16])
		&& st_ff.bank[bankSel][1] == $past(wrData[15:0]))
	else $error("high pair write missed a half");

	a_addr_pair: assert property ( // RULE_05
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_APAIR
		|=> {addrOne, addrZero} == $past(wrData))
	else $error("address pair write wrong");

	a_half_high: assert property ( // RULE_23
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_D1H
		|=> st_ff.bank[bankSel][1] == {$past(wrData[7:0]),
			$past(st_ff.bank[bankSel][1][7:0])})
	else $error("high byte write disturbed low half");

	a_fb_write: assert property ( // RULE_06
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_FB
		|=> frameBase == $past(wrData[15:0]))
	else $error("frame base write lost");

	a_vector_table_base_write: assert property ( // RULE_07
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_VECTOR_TABLE_BASE
		|=> vectorTableBase == $past(wrData[19:0]))
	else $error("vector table base write lost");

	a_sb_write: assert property ( // RULE_12
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_SB
		|=> staticBase == $past(wrData[15:0]))
	else $error("static base write lost");

	a_flg_write: assert property ( // RULE_13
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_FLG && !aluFlagWe && !hwIntAck
		&& !swIntExec
		|=> processorFlags == $past(wrData[10:0]))
	else $error("flag register write lost");

	a_bank_flag: assert property ( // RULE_18
		@(posedge clk_sys) disable iff (reset)
		wrStb && regAddr == REG_FLG
		|=> bankSel == $past(wrData[FLG_B]))
	else $error("bank select not taken from flag write");

	a_pc_load: assert property ( // RULE_08
		@(posedge clk_sys) disable iff (reset)
		pcLoad |=> programCounter == $past(pcLoadVal))
	else $error("program counter load lost");

	a_pc_step: assert property ( // RULE_08
		@(posedge clk_sys) disable iff (reset)
		!pcLoad && pcInc
		|=> programCounter == $past(programCounter)
		+ 20'($past(pcIncAmt)))
	else $error("program counter step wrong");

	a_pc_hold: assert property ( // RULE_08
		@(posedge clk_sys) disable iff (reset)
		!pcLoad && !pcInc && !(wrStb && regAddr == REG_PC)
		|=> $stable(programCounter))
	else $error("program counter moved on its own");

	a_rd_idle: assert property ( // RULE_01
		@(posedge clk_sys) disable iff (reset)
		!rdStb |=> rdData == '0)
	else $error("read data outside its cycle");

	// reset must win, so this one is not disabled by it
	a_reset_state: assert property ( // RULE_01
		@(posedge clk_sys)
		reset |=> rdData == '0 && processorFlags == '0
		&& programCounter == '0 && activeSp == '0)
	else $error("state not cleared by reset");

	a_pc_read: assert property ( // RULE_08
		@(posedge clk_sys) disable iff (reset)
		rdStb && regAddr == REG_PC
		|=> rdData == {12'h000, $past(programCounter)} ##1 rdData == '0
		|| $past(rdStb))
	else $error("program counter read wrong");

	a_zero_flag: assert property ( // RULE_15
		@(posedge clk_sys) disable iff (reset)
		aluFlagWe && !aluByteOp && !(wrStb && regAddr == REG_FLG)
		|=> processorFlags[FLG_Z] == ($past(aluResult) == 16'h0000)
		&& processorFlags[FLG_S] == $past(aluResult[15]))
	else $error("zero or sign flag wrong");

	a_byte_flags: assert property ( // RULE_16
		@(posedge clk_sys) disable iff (reset)
		aluFlagWe && aluByteOp
		|=> processorFlags[FLG_S] == $past(aluResult[7])
		&& processorFlags[FLG_Z] == ($past(aluResult[7:0]) == 8'h00))
	else $error("byte zero or sign flag wrong");

	a_carry_flag: assert property ( // RULE_14
		@(posedge clk_sys) disable iff (reset)
		aluFlagWe |=> processorFlags[FLG_C] == $past(aluCarry))
	else $error("carry flag wrong");

	a_ovf_flag: assert property ( // RULE_17
		@(posedge clk_sys) disable iff (reset)
		aluFlagWe |=> processorFlags[FLG_O] == $past(aluOverflow))
	else $error("overflow flag wrong");

endmodule

// [dv/seq_model.sv]
// sequencer, alu and interrupt side model driving the register file
`timescale 1ns/1ps
module seq_model import cpu_regs_pkg::*; (
	input wire logic clk_sys, // core clock
	output logic pcLoad, // load program counter
	output logic [ADDR20_W-1:0] pcLoadVal, // jump target
	output logic pcInc, // advance program counter
	output logic [2:0] pcIncAmt, // instruction length
	output logic spAdj, // adjust active stack pointer
	output logic [WORD_W-1:0] spDelta, // stack delta
	output logic aluFlagWe, // update flags
	output logic aluByteOp, // byte result
	output logic [WORD_W-1:0] aluResult, // alu result
	output logic aluCarry, // carry out
	output logic aluOverflow, // overflow
	output logic irqRequest, // request pending
	output logic [IPL_W-1:0] irqPriority, // its priority
	output logic hwIntAck, // interrupt acknowledge
	output logic swIntExec, // software interrupt
	output logic [VEC_W-1:0] swIntVector // its vector
);
	// ****
	// idle levels
	// ****
	initial begin
		{pcLoad, pcLoadVal, pcInc, pcIncAmt, spAdj, spDelta} = '0;
		{aluFlagWe, aluByteOp, aluResult, aluCarry, aluOverflow} = '0;
		{irqRequest, irqPriority, hwIntAck, swIntExec, swIntVector} = '0;
	end
	// ****
	// one-cycle operations, launched after a rising edge
	// ****
	task automatic jump(input logic [ADDR20_W-1:0] v);
		@(posedge clk_sys);
		pcLoad <= 1'h1;
		pcLoadVal <= v;
		@(posedge clk_sys);
		pcLoad <= 1'h0;
	endtask
	task automatic step(input logic [2:0] n);
		@(posedge clk_sys);
		pcInc <= 1'h1;
		pcIncAmt <= n;
		@(posedge clk_sys);
		pcInc <= 1'h0;
	endtask
	task automatic sp(input logic [WORD_W-1:0] d);
		@(posedge clk_sys);
		spAdj <= 1'h1;
		spDelta <= d;
		@(posedge clk_sys);
		spAdj <= 1'h0;
	endtask
	task automatic alu(input logic [WORD_W-1:0] r, input logic c, o, b);
		@(posedge clk_sys);
		aluFlagWe <= 1'h1;
		aluResult <= r;
		aluCarry <= c;
		aluOverflow <= o;
		aluByteOp <= b;
		@(posedge clk_sys);
		aluFlagWe <= 1'h0;
	endtask
	task automatic ack();
		@(posedge clk_sys);
		hwIntAck <= 1'h1;
		@(posedge clk_sys);
		hwIntAck <= 1'h0;
	endtask
	task automatic swi(input logic [VEC_W-1:0] v);
		@(posedge clk_sys);
		swIntExec <= 1'h1;
		swIntVector <= v;
		@(posedge clk_sys);
		swIntExec <= 1'h0;
	endtask
	// request level held until changed
	task automatic irq(input logic r, input logic [IPL_W-1:0] p);
		@(posedge clk_sys);
		irqRequest <= r;
		irqPriority <= p;
	endtask
endmodule

// [dv/cpu_register_file_flags_bench.sv]
// self-checking bench for the cpu register file and flags
`timescale 1ns/1ps
module cpu_register_file_flags_bench import cpu_regs_pkg::*;;
	logic clk_sys = 1'h0;
	logic reset = 1'h1;
	logic [RADDR_W-1:0] regAddr = '0;
	logic [BUS_W-1:0] wrData = '0;
	logic wrStb = 1'h0;
	logic rdStb = 1'h0;
	logic [BUS_W-1:0] rdData;
	logic pcLoad, pcInc, spAdj, aluFlagWe, aluByteOp, aluCarry;
	logic aluOverflow, irqRequest, irqAccept, hwIntAck, swIntExec, bankSel;
	logic [ADDR20_W-1:0] pcLoadVal, programCounter, vectorTableBase;
	logic [2:0] pcIncAmt;
	logic [IPL_W-1:0] irqPriority;
	logic [VEC_W-1:0] swIntVector;
	logic [WORD_W-1:0] spDelta, aluResult, addrZero, addrOne, frameBase;
	logic [WORD_W-1:0] staticBase, activeSp;
	logic [FLG_W-1:0] processorFlags;
	int error_cnt = 0;
	int comparisons = 0;
	// ****
	// clock, design and sequencer model
	// ****
	always #5 clk_sys = ~clk_sys;
	cpu_register_file_flags i_dut (
		.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.pcLoad(pcLoad), .pcLoadVal(pcLoadVal), .pcInc(pcInc),
		.pcIncAmt(pcIncAmt), .spAdj(spAdj), .spDelta(spDelta),
		.aluFlagWe(aluFlagWe), .aluByteOp(aluByteOp),
		.aluResult(aluResult), .aluCarry(aluCarry),
		.aluOverflow(aluOverflow), .irqRequest(irqRequest),
		.irqPriority(irqPriority), .irqAccept(irqAccept),
		.hwIntAck(hwIntAck), .swIntExec(swIntExec),
		.swIntVector(swIntVector), .bankSel(bankSel),
		.addrZero(addrZero), .addrOne(addrOne), .frameBase(frameBase),
		.staticBase(staticBase), .activeSp(activeSp),
		.programCounter(programCounter),
		.vectorTableBase(vectorTableBase),
		.processorFlags(processorFlags)
	);
	seq_model i_seq (
		.clk_sys(clk_sys), .pcLoad(pcLoad), .pcLoadVal(pcLoadVal),
		.pcInc(pcInc), .pcIncAmt(pcIncAmt), .spAdj(spAdj),
		.spDelta(spDelta), .aluFlagWe(aluFlagWe), .aluByteOp(aluByteOp),
		.aluResult(aluResult), .aluCarry(aluCarry),
		.aluOverflow(aluOverflow), .irqRequest(irqRequest),
		.irqPriority(irqPriority), .hwIntAck(hwIntAck),
		.swIntExec(swIntExec), .swIntVector(swIntVector)
	);
	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wrStb <= 1'h1;
		regAddr <= a;
		wrData <= d;
		@(posedge clk_sys);
		wrStb <= 1'h0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		rdStb <= 1'h1;
		regAddr <= a;
		@(posedge clk_sys);
		rdStb <= 1'h0;
		@(negedge clk_sys);
		chk(rdData, e);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_map();
		for (int i = 0; i < 13; i++) rd(5'(i), 32'h0);
		for (int i = 0; i < 12; i++) begin
			wr(5'(i), 32'hFFFFFFFF);
			rd(5'(i), (i == 7 || i == 8) ? 32'h000FFFFF : 32'h0000FFFF);
		end
		@(negedge clk_sys);
		chk(32'(vectorTableBase), 32'h000FFFFF);
		chk(32'(staticBase), 32'h0000FFFF);
		wr(REG_FLG, 32'hFFFFFFFF);
		rd(REG_FLG, 32'h000007FF);
		wr(REG_FLG, 32'h0);
		wr(5'h15, 32'h00001234);
		rd(5'h15, 32'h0);
		$display("test map done");
	endtask
	task automatic t_bytes();
		wr(REG_D0, 32'h1234);
		wr(REG_D0L, 32'hAB);
		rd(REG_D0, 32'h12AB);
		wr(REG_D1, 32'h5678);
		wr(REG_D1H, 32'hCD);
		rd(REG_D1, 32'hCD78);
		rd(REG_D0H, 32'h12);
		rd(REG_D1L, 32'h78);
		$display("test bytes done");
	endtask
	task automatic t_pairs();
		wr(REG_D2, 32'h2222);
		rd(REG_DPAIRL, 32'h222212AB);
		wr(REG_DPAIRH, 32'hBEEFCAFE);
		rd(REG_D3, 32'hBEEF);
		rd(REG_D1, 32'hCAFE);
		wr(REG_APAIR, 32'h0A1A0A0A);
		@(negedge clk_sys);
		chk(32'({addrOne, addrZero}), 32'h0A1A0A0A);
		$display("test pairs done");
	endtask
	task automatic t_banks();
		wr(REG_FB, 32'h0FB0);
		wr(REG_FLG, 32'h010);
		@(negedge clk_sys);
		chk(32'({bankSel, frameBase}), 32'h10000);
		rd(REG_D0, 32'h0);
		wr(REG_D0, 32'h0BBB);
		wr(REG_FLG, 32'h0);
		rd(REG_D0, 32'h12AB);
		@(negedge clk_sys);
		chk(32'({bankSel, frameBase}), 32'h00FB0);
		$display("test banks done");
	endtask
	task automatic t_stack();
		wr(REG_ISP, 32'h0100);
		wr(REG_USP, 32'h0200);
		@(negedge clk_sys);
		chk(32'(activeSp), 32'h0100);
		wr(REG_FLG, 32'h0C0);
		i_seq.sp(16'hFFFE);
		rd(REG_USP, 32'h01FE);
		i_seq.ack();
		@(negedge clk_sys);
		chk(32'(processorFlags & 11'h0C0), 32'h0);
		chk(32'(activeSp), 32'h0100);
		wr(REG_SPACT, 32'h0140);
		rd(REG_ISP, 32'h0140);
		rd(REG_SPACT, 32'h0140);
		wr(REG_FLG, 32'h080);
		i_seq.swi(6'h20);
		@(negedge clk_sys);
		chk(32'(processorFlags), 32'h080);
		i_seq.swi(6'h1F);
		@(negedge clk_sys);
		chk(32'(processorFlags), 32'h0);
		$display("test stack done");
	endtask
	task automatic t_alu();
		i_seq.alu(16'h0000, 1'h0, 1'h0, 1'h0);
		@(negedge clk_sys);
		chk(32'(processorFlags & 11'h02D), 32'h004);
		i_seq.alu(16'h8000, 1'h1, 1'h1, 1'h0);
		@(negedge clk_sys);
		chk(32'(processorFlags & 11'h02D), 32'h029);
		i_seq.alu(16'h0100, 1'h0, 1'h0, 1'h1);
		@(negedge clk_sys);
		chk(32'(processorFlags & 11'h02D), 32'h004);
		i_seq.alu(16'h0080, 1'h0, 1'h0, 1'h1);
		@(negedge clk_sys);
		chk(32'(processorFlags & 11'h02D), 32'h008);
		$display("test alu done");
	endtask
	task automatic t_irq();
		wr(REG_FLG, 32'h340);
		i_seq.irq(1'h1, 3'h3);
		@(negedge clk_sys);
		chk(32'(irqAccept), 32'h0);
		i_seq.irq(1'h1, 3'h4);
		@(negedge clk_sys);
		chk(32'(irqAccept), 32'h1);
		wr(REG_FLG, 32'h300);
		@(negedge clk_sys);
		chk(32'(irqAccept), 32'h0);
		wr(REG_FLG, 32'h740);
		rd(REG_FLG, 32'h740);
		i_seq.irq(1'h1, 3'h7);
		@(negedge clk_sys);
		chk(32'(irqAccept), 32'h0);
		i_seq.irq(1'h0, 3'h0);
		$display("test irq done");
	endtask
	task automatic t_pc();
		i_seq.jump(20'hFFFFF);
		@(negedge clk_sys);
		chk(32'(programCounter), 32'hFFFFF);
		i_seq.step(3'h3);
		rd(REG_PC, 32'h00002);
		$display("test pc done");
	endtask
	// ****
	// main sequence and watchdog
	// ****
	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'h0;
		t_map();
		t_bytes();
		t_pairs();
		t_banks();
		t_stack();
		t_alu();
		t_irq();
		t_pc();
		wrap_up();
	end
	initial begin
		#50us;
		error_cnt++;
		wrap_up();
	end
endmodule
